// *** rtl/sfp_pkg.sv ***
/*
 Package for the serial flash pin front end: sync bit positions, state and
 lane-mode codes, status layout, reset values and the lane width decode.
 Assumes one 100 MHz system clock that oversamples every pin.
*/
`default_nettype none
package sfp_pkg;
   // ----------------------------------------
   // synchroniser bit positions
   // ----------------------------------------
   localparam int SYNC_W = 7;
   localparam int SY_SCLK = 0;
   localparam int SY_CS = 1;
   localparam int SY_LANE0 = 2; // lanes 0..3 at 2..5
   localparam int SY_RSTPIN = 6;
   // cs bit resets low so a select held at power-up is never seen as a fall
   localparam logic [6:0] SYNC_RST = 7'h7D;

   // ----------------------------------------
   // status bit layout
   // ----------------------------------------
   localparam int SR_LOCK = 5;
   localparam int SR_QE = 4;
   localparam logic [5:0] SR_RST = 6'h00;

   // ----------------------------------------
   // lane modes, states and counts
   // ----------------------------------------
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_DUAL = 2'h1;
   localparam logic [1:0] MODE_QUAD = 2'h2;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] OE_ALL_OFF = 4'hF;
   localparam logic [3:0] OE_QUAD = 4'h0;
   localparam logic [3:0] OE_DUAL = 4'hC;
   localparam logic [3:0] OE_SINGLE = 4'hD;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ACT = 4'h2,
      ST_PAUSE = 4'h4,
      ST_RESET = 4'h8
   } sfp_state_t;

   typedef struct packed {
      logic [6:0] meta;
      logic [6:0] sync;
      logic sclk_d;
      logic cs_d;
      sfp_state_t st;
      logic [7:0] rx_sh;
      logic [3:0] rx_cnt;
      logic [7:0] rx_byte;
      logic rx_valid;
      logic [7:0] tx_sh;
      logic [3:0] tx_cnt;
      logic tx_take;
      logic [3:0] lane_o;
      logic [3:0] lane_oe_n;
      logic [5:0] sr;
      logic sr_blocked;
   } sfp_reg_t;

   // sclk delay resets high like its sync bit, so leaving reset makes no false edge
   localparam sfp_reg_t SFP_REG_RST = '{meta: SYNC_RST, sync: SYNC_RST, sclk_d: 1'b1, cs_d: 1'b0,
      st: ST_IDLE, rx_sh: 8'h00, rx_cnt: 4'h0, rx_byte: 8'h00, rx_valid: 1'b0, tx_sh: 8'h00,
      tx_cnt: 4'h0, tx_take: 1'b0, lane_o: 4'h0, lane_oe_n: OE_ALL_OFF, sr: SR_RST, sr_blocked: 1'b0};

   // bits moved per clock edge; quad needs the quad enable bit
   function automatic logic [3:0] sfp_width(input logic [1:0] mode, input logic qe);
      logic [3:0] w;
      w = 4'h1;
      if (mode == MODE_DUAL)
         w = 4'h2;
      else if (mode == MODE_QUAD && qe)
         w = 4'h4;
      return w;
   endfunction
endpackage
`default_nettype wire

// *** rtl/sfp_frontend.sv ***
/*
 Pin front end of a multi-lane serial flash: select, shift, pause, reset and
 status write protection. Assumes every pin input is asynchronous to clk and
 that the serial clock runs well below a quarter of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module sfp_frontend
   import sfp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic [3:0] data_lane_i,
   input wire logic reset_pin_n,
   input wire logic [1:0] lane_mode,
   input wire logic out_phase,
   input wire logic [7:0] tx_byte,
   input wire logic sr_wr,
   input wire logic [5:0] sr_wr_data,
   input wire logic pause_or_reset_select,
   input wire logic ded_reset_en,
   output logic [3:0] data_lane_o,
   output logic [3:0] data_lane_oe_n,
   output logic selected,
   output logic paused,
   output logic in_reset,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic tx_take,
   output logic status_lock_enable,
   output logic quad_enable_bit,
   output logic [3:0] block_protect,
   output logic sr_wr_blocked
);
   sfp_reg_t r_r;
   sfp_reg_t r_nxt;

   // ----------------------------------------
   // decoded pin functions
   // ----------------------------------------
   logic sclk_s, cs_s, protect_pin_n, pause_pin_n, rst_pin_s;
   logic rise, fall, cs_fall, lane3_pause, lane3_reset, pause_req, reset_req, wp_active;
   logic [3:0] w;
   logic [4:0] rx_sum, tx_sum;
   logic [7:0] tx_cur;

   always_comb begin
      sclk_s = r_r.sync[SY_SCLK];
      cs_s = r_r.sync[SY_CS];
      protect_pin_n = r_r.sync[SY_LANE0 + 2];
      pause_pin_n = r_r.sync[SY_LANE0 + 3];
      rst_pin_s = r_r.sync[SY_RSTPIN];
      // edges only, so idle level of mode 0 or 3 is irrelevant
      rise = sclk_s & ~r_r.sclk_d;
      fall = ~sclk_s & r_r.sclk_d;
      cs_fall = r_r.cs_d & ~cs_s;
      // lane 3 function: data only under quad enable
      lane3_pause = ~r_r.sr[SR_QE] & (ded_reset_en | ~pause_or_reset_select);
      lane3_reset = ~r_r.sr[SR_QE] & ~ded_reset_en & pause_or_reset_select;
      pause_req = lane3_pause & ~pause_pin_n;
      reset_req = (ded_reset_en & ~rst_pin_s) | (lane3_reset & ~pause_pin_n);
      wp_active = ~r_r.sr[SR_QE] & r_r.sr[SR_LOCK] & ~protect_pin_n;
      w = sfp_width(lane_mode, r_r.sr[SR_QE]);
      rx_sum = {1'b0, r_r.rx_cnt} + {1'b0, w};
      tx_sum = {1'b0, r_r.tx_cnt} + {1'b0, w};
      tx_cur = (r_r.tx_cnt == 4'h0) ? tx_byte : r_r.tx_sh;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      r_nxt = r_r;
      r_nxt.meta = {reset_pin_n, data_lane_i, chip_select_n, sclk};
      r_nxt.sync = r_r.meta;
      r_nxt.sclk_d = sclk_s;
      r_nxt.cs_d = cs_s;
      r_nxt.rx_valid = 1'b0;
      r_nxt.tx_take = 1'b0;
      r_nxt.sr_blocked = 1'b0;
      // status write, gated by lock and protect pin while quad enable is clear
      if (sr_wr) begin
         if (wp_active)
            r_nxt.sr_blocked = 1'b1;
         else
            r_nxt.sr = sr_wr_data;
      end
      case (r_r.st)
         ST_IDLE: begin
            r_nxt.lane_oe_n = OE_ALL_OFF;
            r_nxt.rx_cnt = 4'h0;
            r_nxt.tx_cnt = 4'h0;
            if (reset_req)
               r_nxt.st = ST_RESET;
            else if (cs_fall)
               r_nxt.st = ST_ACT;
         end
         ST_ACT: begin
            if (reset_req) begin
               r_nxt.st = ST_RESET;
               r_nxt.lane_oe_n = OE_ALL_OFF;
            end else if (cs_s) begin
               r_nxt.st = ST_IDLE;
               r_nxt.lane_oe_n = OE_ALL_OFF;
            end else if (pause_req) begin
               r_nxt.st = ST_PAUSE;
               r_nxt.lane_oe_n = OE_ALL_OFF;
            end else begin
               // inbound bits on rising edges
               if (rise && !out_phase) begin
                  case (w)
                     4'h4: r_nxt.rx_sh = {r_r.rx_sh[3:0], r_r.sync[SY_LANE0 +: 4]};
                     4'h2: r_nxt.rx_sh = {r_r.rx_sh[5:0], r_r.sync[SY_LANE0 +: 2]};
                     default: r_nxt.rx_sh = {r_r.rx_sh[6:0], r_r.sync[SY_LANE0]};
                  endcase
                  if (rx_sum[3:0] == BITS_PER_BYTE) begin
                     r_nxt.rx_cnt = 4'h0;
                     r_nxt.rx_byte = r_nxt.rx_sh;
                     r_nxt.rx_valid = 1'b1;
                  end else begin
                     r_nxt.rx_cnt = rx_sum[3:0];
                  end
               end
               // outbound bits change on falling edges
               if (!out_phase) begin
                  r_nxt.lane_oe_n = OE_ALL_OFF;
               end else if (fall) begin
                  r_nxt.tx_take = (r_r.tx_cnt == 4'h0);
                  case (w)
                     4'h4: begin
                        r_nxt.lane_o = tx_cur[7:4];
                        r_nxt.lane_oe_n = OE_QUAD;
                     end
                     4'h2: begin
                        r_nxt.lane_o = {2'h0, tx_cur[7:6]};
                        r_nxt.lane_oe_n = OE_DUAL;
                     end
                     default: begin
                        r_nxt.lane_o = {2'h0, tx_cur[7], 1'b0};
                        r_nxt.lane_oe_n = OE_SINGLE;
                     end
                  endcase
                  r_nxt.tx_sh = tx_cur << w;
                  r_nxt.tx_cnt = (tx_sum[3:0] == BITS_PER_BYTE) ? 4'h0 : tx_sum[3:0];
               end
            end
         end
         ST_PAUSE: begin
            // shifters and counts frozen, clock edges dropped
            r_nxt.lane_oe_n = OE_ALL_OFF;
            if (reset_req)
               r_nxt.st = ST_RESET;
            else if (cs_s)
               r_nxt.st = ST_IDLE;
            else if (!pause_req)
               r_nxt.st = ST_ACT;
         end
         ST_RESET: begin
            r_nxt.lane_oe_n = OE_ALL_OFF;
            r_nxt.rx_cnt = 4'h0;
            r_nxt.tx_cnt = 4'h0;
            if (!reset_req)
               r_nxt.st = ST_IDLE;
         end
         default: begin
            r_nxt.st = ST_IDLE;
            r_nxt.lane_oe_n = OE_ALL_OFF;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         r_r <= SFP_REG_RST;
      else
         r_r <= r_nxt;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign data_lane_o = r_r.lane_o;
   assign data_lane_oe_n = r_r.lane_oe_n;
   assign selected = (r_r.st == ST_ACT) | (r_r.st == ST_PAUSE);
   assign paused = (r_r.st == ST_PAUSE);
   assign in_reset = (r_r.st == ST_RESET);
   assign rx_byte = r_r.rx_byte;
   assign rx_valid = r_r.rx_valid;
   assign tx_take = r_r.tx_take;
   assign status_lock_enable = r_r.sr[SR_LOCK];
   assign quad_enable_bit = r_r.sr[SR_QE];
   assign block_protect = r_r.sr[3:0];
   assign sr_wr_blocked = r_r.sr_blocked;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_desel_hiz: assert property ((r_r.st == ST_ACT) && cs_s && !reset_req |=>
      (r_r.st == ST_IDLE) && (r_r.lane_oe_n == OE_ALL_OFF)) else $error("deselect left a lane driven");
   chk_select_needs_fall: assert property ((r_r.st == ST_IDLE) && !cs_fall |=> r_r.st != ST_ACT)
      else $error("active without select fall");
   chk_select_active: assert property ((r_r.st == ST_IDLE) && cs_fall && !reset_req |=> selected)
      else $error("select fall not taken");
   chk_single_sample: assert property ((r_r.st == ST_ACT) && rise && !out_phase && (w == 4'h1) && !cs_s
      && !pause_req && !reset_req |=> r_r.rx_sh[0] == $past(r_r.sync[SY_LANE0])) else $error("lane 0 not sampled");
   chk_single_drive: assert property ((r_r.st == ST_ACT) && fall && out_phase && (w == 4'h1) && !cs_s
      && !pause_req && !reset_req |=> !r_r.lane_oe_n[1] && r_r.lane_oe_n[0]) else $error("lane 1 not driven");
   chk_quad_drive: assert property ((r_r.st == ST_ACT) && fall && out_phase && (w == 4'h4) && !cs_s
      && !pause_req && !reset_req |=> r_r.lane_oe_n == OE_QUAD) else $error("quad lanes not driven");
   chk_sr_locked: assert property (sr_wr && wp_active |=> $stable(r_r.sr) && r_r.sr_blocked)
      else $error("locked status written");
   chk_sr_open: assert property (sr_wr && (!r_r.sr[SR_LOCK] || r_r.sr[SR_QE]) |=>
      r_r.sr == $past(sr_wr_data)) else $error("open status write lost");
   chk_pause_hiz: assert property ((r_r.st == ST_ACT) && pause_req && !cs_s && !reset_req |=>
      paused && (r_r.lane_oe_n == OE_ALL_OFF)) else $error("pause not entered");
   chk_pause_frozen: assert property (paused && $past(paused) |-> $stable(r_r.rx_sh)
      && $stable(r_r.rx_cnt) && $stable(r_r.tx_cnt)) else $error("shift during pause");
   chk_resume: assert property (paused && !pause_req && !cs_s && !reset_req |=> r_r.st == ST_ACT)
      else $error("pause release not resumed");
   chk_reset_hiz: assert property (reset_req |=> in_reset && (r_r.lane_oe_n == OE_ALL_OFF))
      else $error("reset left outputs on");
endmodule
`default_nettype wire

// *** testbench/sfp_host.sv ***
/*
 spi host model for the flash pin front end: select, serial clock, lane data.
 assumes the bench clock paces it; serial clock low 5 and high 3 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module sfp_host (
   input wire logic clk,
   input wire logic [3:0] lane,
   output logic sclk,
   output logic chip_select_n,
   output logic [3:0] drv
);
   // ----------------------------------------
   // pin levels and transfer tasks
   // ----------------------------------------
   // select low from power-up, so the first fall has to be made on purpose
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b0;
      drv = 4'hF;
   end

   // move select, then give the synchroniser time before any clock edge
   task automatic sel(input logic n);
      @(posedge clk);
      chip_select_n <= n;
      repeat (4) @(posedge clk);
   endtask

   // n pulses of w bits, msb first, higher lane first; lane 1 read at each rise
   task automatic xfer(input logic [7:0] v, input int w, input int n, output logic [7:0] got);
      logic [7:0] s;
      logic [3:0] d;
      s = v;
      got = 8'h00;
      repeat (n) begin
         @(posedge clk);
         d = drv;
         for (int k = 0; k < w; k++) begin
            d[k] = s[8-w+k];
         end
         s = s << w;
         sclk <= 1'b0;
         drv <= d;
         repeat (5) @(posedge clk);
         sclk <= 1'b1;
         got = {got[6:0], lane[1]};
         repeat (2) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// *** testbench/sfp_frontend_bench.sv ***
/*
 self-checking bench for the flash pin front end with the spi host model.
 assumes sfp_pkg and sfp_host; 100 MHz clock, 80 ns serial clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sfp_frontend_bench;
   import sfp_pkg::*;
   logic clk, rst, reset_pin_n, out_phase, sr_wr, prs, ded, sclk, cs_n;
   logic selected, paused, in_reset, rx_valid, tx_take, lock, qe, blk;
   logic [1:0] lane_mode;
   logic [3:0] o, oe_n, drv, lane, bp;
   logic [5:0] sr_wr_data;
   logic [7:0] tx_byte, rx_byte, got;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [7:0] rx_pulses = 8'h00;
   logic [7:0] take_pulses = 8'h00;
   // prior status, protect pin, write data, expected status, expected refusal
   logic [31:0] rows [4] = '{32'h0002F2F0, 32'h2012A2A0, 32'h20005201, 32'h30013130};

   // ----------------------------------------
   // wiring
   // ----------------------------------------
   // an enabled device lane wins over the host
   assign lane = (oe_n & drv) | (~oe_n & o);

   sfp_host u_sfp_host (.clk(clk), .lane(lane), .sclk(sclk), .chip_select_n(cs_n), .drv(drv));

   sfp_frontend u_sfp_frontend (.clk(clk), .rst(rst), .sclk(sclk), .chip_select_n(cs_n), .data_lane_i(lane),
      .reset_pin_n(reset_pin_n), .lane_mode(lane_mode), .out_phase(out_phase), .tx_byte(tx_byte),
      .sr_wr(sr_wr), .sr_wr_data(sr_wr_data), .pause_or_reset_select(prs), .ded_reset_en(ded),
      .data_lane_o(o), .data_lane_oe_n(oe_n), .selected(selected), .paused(paused), .in_reset(in_reset),
      .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_take(tx_take), .status_lock_enable(lock),
      .quad_enable_bit(qe), .block_protect(bp), .sr_wr_blocked(blk));

   // ----------------------------------------
   // clock, guard and helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         finish_test();
      end
   end

   // count one-cycle pulses so none slips between checks
   always @(posedge clk) begin
      if (rx_valid === 1'b1)
         rx_pulses <= rx_pulses + 8'h01;
      if (tx_take === 1'b1)
         take_pulses <= take_pulses + 8'h01;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // wait edges, then step off the edge so outputs have settled
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // set protect pin, let it pass the synchroniser, then pulse a status write
   task automatic sw(input logic prot, input logic [5:0] d);
      @(posedge clk);
      u_sfp_host.drv[2] <= prot;
      sr_wr_data <= d;
      repeat (4) @(posedge clk);
      sr_wr <= 1'b1;
      @(posedge clk);
      sr_wr <= 1'b0;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      reset_pin_n = 1'b1;
      out_phase = 1'b0;
      sr_wr = 1'b0;
      prs = 1'b0;
      ded = 1'b1;
      lane_mode = MODE_SINGLE;
      sr_wr_data = 6'h00;
      tx_byte = 8'h00;
      wt(12);
      check("reset oe", oe_n, OE_ALL_OFF);
      check("reset status", {lock, qe, bp}, SR_RST);
      $display("reset done");
      @(posedge clk);
      rst <= 1'b0;
      // status write table
      foreach (rows[i]) begin
         sw(1'b1, rows[i][29:24]);
         sw(rows[i][20], rows[i][17:12]);
         #1;
         check("status", {lock, qe, bp}, rows[i][9:4]);
         check("refused", blk, rows[i][0]);
      end
      $display("status table done");
      // select held low since reset is not a fall
      sw(1'b1, 6'h00);
      u_sfp_host.xfer(8'h5A, 1, 8, got);
      wt(3);
      check("no select", selected, 1'b0);
      check("no byte", rx_byte, 8'h00);
      // park the serial clock low so the next byte runs in mode 0
      @(posedge clk);
      u_sfp_host.sclk <= 1'b0;
      u_sfp_host.sel(1'b1);
      u_sfp_host.sel(1'b0);
      wt(1);
      check("select", selected, 1'b1);
      u_sfp_host.xfer(8'hA5, 1, 8, got);
      wt(3);
      check("rx idle low", rx_byte, 8'hA5);
      u_sfp_host.xfer(8'h3C, 1, 8, got);
      wt(3);
      check("rx idle high", rx_byte, 8'h3C);
      $display("single receive done");
      // pause in mid byte; clock pulses while paused must not count
      u_sfp_host.xfer(8'h96, 1, 4, got);
      u_sfp_host.drv[3] <= 1'b0;
      wt(4);
      check("paused", paused, 1'b1);
      check("pause oe", oe_n, OE_ALL_OFF);
      u_sfp_host.xfer(8'h00, 1, 4, got);
      u_sfp_host.drv[3] <= 1'b1;
      wt(4);
      u_sfp_host.xfer(8'h60, 1, 4, got);
      wt(3);
      check("resume", rx_byte, 8'h96);
      $display("pause done");
      @(posedge clk);
      out_phase <= 1'b1;
      tx_byte <= 8'hC3;
      u_sfp_host.xfer(8'h00, 1, 8, got);
      wt(1);
      check("tx single", got, 8'hC3);
      check("single oe", oe_n, OE_SINGLE);
      // quad and dual lanes
      @(posedge clk);
      out_phase <= 1'b0;
      sw(1'b1, 6'h10);
      lane_mode <= MODE_QUAD;
      u_sfp_host.xfer(8'hE1, 4, 2, got);
      wt(3);
      check("rx quad", rx_byte, 8'hE1);
      check("lane 3 data", paused, 1'b0);
      @(posedge clk);
      out_phase <= 1'b1;
      u_sfp_host.xfer(8'h00, 4, 2, got);
      wt(1);
      check("quad oe", oe_n, OE_QUAD);
      check("quad data", lane, 8'h03);
      check("quad lane 1", got, 8'h01);
      @(posedge clk);
      out_phase <= 1'b0;
      lane_mode <= MODE_DUAL;
      u_sfp_host.xfer(8'hB4, 2, 4, got);
      wt(3);
      check("rx dual", rx_byte, 8'hB4);
      @(posedge clk);
      out_phase <= 1'b1;
      u_sfp_host.xfer(8'h00, 2, 4, got);
      wt(1);
      check("dual oe", oe_n, OE_DUAL);
      check("dual data", lane[1:0], 8'h03);
      check("dual lane 1", got, 8'h09);
      $display("multi lane done");
      // lane 3 function select and reset
      u_sfp_host.sel(1'b1);
      wt(1);
      check("deselect oe", oe_n, OE_ALL_OFF);
      check("deselect", selected, 1'b0);
      sw(1'b1, 6'h00);
      ded <= 1'b0;
      prs <= 1'b1;
      u_sfp_host.drv <= 4'h7;
      wt(4);
      check("lane 3 reset", in_reset, 1'b1);
      @(posedge clk);
      u_sfp_host.drv <= 4'hF;
      ded <= 1'b1;
      u_sfp_host.sel(1'b0);
      u_sfp_host.drv[3] <= 1'b0;
      wt(4);
      check("dedicated pause", paused, 1'b1);
      check("dedicated no reset", in_reset, 1'b0);
      @(posedge clk);
      ded <= 1'b0;
      prs <= 1'b0;
      wt(4);
      check("select pause", paused, 1'b1);
      @(posedge clk);
      u_sfp_host.drv[3] <= 1'b1;
      ded <= 1'b1;
      reset_pin_n <= 1'b0;
      wt(4);
      check("reset pin", in_reset, 1'b1);
      check("reset pin oe", oe_n, OE_ALL_OFF);
      $display("lane 3 functions done");
      check("rx pulses", rx_pulses, 8'h05);
      check("take pulses", take_pulses, 8'h03);
      finish_test();
   end
endmodule
`default_nettype wire
